// ### tb/vrc_core_props.sv
// Checker for the range control bus and oscillator outputs
`default_nettype none
module vrc_core_props (
  // Clock, reset, bus
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Interrupt and controls
  input wire logic        irq,
  input wire logic [2:0]  divide_ratio,
  input wire logic        bias_auto,
  input wire logic [2:0]  bias_override,
  input wire logic [2:0]  cap_bank_setting,
  input wire logic [1:0]  pump_current_ext,
  input wire logic [1:0]  pump_current_int
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Write finishing at this edge
  logic wr_done;
  assign wr_done = pready & pwrite;
  ////////////////////////////////////////
  property p_div; divide_ratio inside {3'h2, 3'h4, 3'h6}; endproperty
  a_div: assert property (p_div) else $error("bad divide ratio");
  property p_bias; $stable(bias_override) |-> bias_auto == (bias_override == 3'h0); endproperty
  a_bias: assert property (p_bias) else $error("bias mode wrong");
  property p_pump; pump_current_ext == pump_current_int; endproperty
  a_pump: assert property (p_pump) else $error("pumps differ");
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("stray read data");
  property p_err;
    pready |-> pslverr == !(paddr inside {8'h2c, 8'h3c, 8'h4c, 8'h50, 8'h58, 8'h60, 8'h64});
  endproperty
  a_err: assert property (p_err) else $error("wrong error answer");
  // Bank moves one step unless software wrote
  property p_step;
    $changed(cap_bank_setting) && !$past(wr_done) && !$past(wr_done, 2)
      |-> 3'(cap_bank_setting - $past(cap_bank_setting)) inside {3'h1, 3'h7};
  endproperty
  a_step: assert property (p_step) else $error("bank jumped");
  property p_irq; irq && !wr_done && !$past(wr_done) |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("flag lost");
  // Main scenarios reached
  c_irq: cover property ($rose(irq));
  c_step: cover property ($changed(cap_bank_setting) && !pready);
  c_err: cover property (pready && pslverr);
endmodule : vrc_core_props
bind vrc_core vrc_core_props i_vrc_core_props (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq),
  .divide_ratio(divide_ratio), .bias_auto(bias_auto), .bias_override(bias_override),
  .cap_bank_setting(cap_bank_setting), .pump_current_ext(pump_current_ext),
  .pump_current_int(pump_current_int)
);
`default_nettype wire

// ### tb/vrc_core_tb.sv
// Self-checking bench for the range control core
`default_nettype none
module vrc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Row: write flag, address, data, expected read
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} vrc_row_t;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        pll_lock, tx_mode, load_pulse, supply_low, lock_ok, bias_auto, oscillator_bypass;
  logic        supply_monitor_enable;
  logic [7:0]  paddr, cv_code, avdd_code;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  divide_ratio, bias_override, cap_bank_setting;
  logic [1:0]  pump_current_ext, pump_current_int;
  int          fail_count, comparisons;
  vrc_row_t    rows [9] = '{'{1'b0, 8'h2c, 8'h00, 8'hae}, '{1'b0, 8'h3c, 8'h00, 8'h00},
    '{1'b0, 8'h4c, 8'h00, 8'ha9}, '{1'b0, 8'h50, 8'h00, 8'he5}, '{1'b0, 8'h58, 8'h00, 8'h00},
    '{1'b0, 8'h64, 8'h00, 8'h00}, '{1'b1, 8'h50, 8'h5a, 8'h5a}, '{1'b1, 8'h4c, 8'h40, 8'h40},
    '{1'b1, 8'h58, 8'h18, 8'h18}};
  ////////////////////////////////////////
  // Design, shortened settle and lock wait
  vrc_core #(.SETTLE_US(2), .LOCK_TIMEOUT(3)) i_vrc_core (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .irq, .pll_lock, .tx_mode, .load_pulse, .supply_low, .cv_code,
    .avdd_code, .divide_ratio, .bias_auto, .bias_override, .cap_bank_setting,
    .oscillator_bypass, .pump_current_ext, .pump_current_int,
    .onchip_filter_enable(), .filter_first_resistor(), .filter_third_resistor(),
    .filter_capacitor_select(), .high_phase_margin(), .onchip_filter_test(),
    .test_output_select(), .supply_monitor_enable, .modulation_select());
  // Analog far side
  vrc_vco_model i_vrc_vco_model (.tx_mode, .cap_bank_setting, .lock_ok, .cv_code,
    .avdd_code, .pll_lock);
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////
  // One bus transfer, released after ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clock);
    if (n == 20) begin
      fail_count++;
      close_out();
    end
  endtask : apb
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("read", {24'h0, e}, rd);
  endtask : rdc
  // Bounded wait for irq or a bank value
  task automatic wt(input logic i, input logic [2:0] b);
    int n;
    for (n = 0; n < 5000 && (i ? irq !== 1'b1 : cap_bank_setting !== b); n++)
      @(posedge clock);
    if (n == 5000) begin
      fail_count++;
      close_out();
    end
  endtask : wt
  task automatic settle;
    repeat (3) @(posedge clock);
  endtask : settle
  // Drop transmit, set tune bits, enter transmit
  task automatic run(input logic [7:0] t);
    tx_mode <= 1'b0;
    apb(1'b1, 8'h3c, t);
    tx_mode <= 1'b1;
  endtask : run
  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask : tend
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, tx_mode, load_pulse, supply_low, paddr, pwdata} = '0;
    {fail_count, comparisons, lock_ok, reset} = {64'h0, 2'b11};
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    settle();
    chk("ratio", 4, divide_ratio);
    chk("bank", 3, cap_bank_setting);
    chk("auto", 1, bias_auto);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    settle();
    chk("pump", 2, pump_current_ext);
    chk("pump", 2, pump_current_int);
    chk("bypass", 1, oscillator_bypass);
    chk("bias", 1, bias_override);
    chk("auto", 0, bias_auto);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, 8'h2c, {1'b0, 2'(b), 5'h0c});
      settle();
      chk("ratio", (b == 0) ? 6 : (b == 1) ? 4 : 2, divide_ratio);
    end
    apb(1'b0, 8'h2d, 8'h00);
    chk("err", 1, err);
    chk("data", 0, rd);
    tend("registers");
    apb(1'b1, 8'h64, 8'h0f);
    apb(1'b1, 8'h2c, 8'h2c);
    run(8'h00);
    repeat (300) @(posedge clock);
    rdc(8'h60, 8'h60);
    run(8'h80);
    wt(1'b1, 3'h0);
    rdc(8'h60, 8'h62);
    apb(1'b1, 8'h60, 8'h02);
    settle();
    chk("irq", 0, irq);
    run(8'h40);
    wt(1'b0, 3'h5);
    repeat (200) @(posedge clock);
    rdc(8'h60, 8'ha0);
    apb(1'b1, 8'h2c, 8'h2c);
    settle();
    chk("bank", 5, cap_bank_setting);
    apb(1'b1, 8'h2c, 8'h28);
    settle();
    chk("bank", 2, cap_bank_setting);
    run(8'hc0);
    wt(1'b0, 3'h5);
    rdc(8'h60, 8'ha2);
    repeat (200) @(posedge clock);
    apb(1'b1, 8'h3c, 8'hc1);
    apb(1'b1, 8'h60, 8'h0f);
    apb(1'b1, 8'h2c, 8'h2c);
    load_pulse <= 1'b1;
    @(posedge clock);
    load_pulse <= 1'b0;
    wt(1'b0, 3'h5);
    tend("tuning");
    repeat (200) @(posedge clock);
    apb(1'b1, 8'h60, 8'h0f);
    lock_ok <= 1'b0;
    run(8'h40);
    repeat (40) @(posedge clock);
    chk("irq", 0, irq);
    wt(1'b1, 3'h0);
    rdc(8'h60, 8'ha8);
    apb(1'b1, 8'h2c, 8'hac);
    chk("supmon", 1, supply_monitor_enable);
    supply_low <= 1'b1;
    @(posedge clock);
    supply_low <= 1'b0;
    settle();
    rdc(8'h60, 8'ha9);
    apb(1'b1, 8'h64, 8'h00);
    settle();
    chk("irq", 0, irq);
    apb(1'b1, 8'h60, 8'h0f);
    rdc(8'h60, 8'ha0);
    tend("events");
    close_out();
  end
endmodule : vrc_core_tb
`default_nettype wire

// ### tb/vrc_vco_model.sv
// Behavioural oscillator bank, varactor and lock detector
`default_nettype none
module vrc_vco_model #(
  parameter logic [2:0] GOOD = 3'h5
) (
  // Bank from the core, transmit and lock enable from the bench
  input  wire logic       tx_mode,
  input  wire logic [2:0] cap_bank_setting,
  input  wire logic       lock_ok,
  // Analog sense
  output logic [7:0]      cv_code,
  output logic [7:0]      avdd_code,
  output logic            pll_lock
);
  timeunit 1ns;
  timeprecision 100ps;
  // Varactor low below the good bank, high above it
  assign cv_code = (cap_bank_setting < GOOD) ? 8'h0a :
                   (cap_bank_setting > GOOD) ? 8'hc8 : 8'h5a;
  // Supply near 1.8 V
  assign avdd_code = 8'hb4;
  // Lock only while transmitting
  assign pll_lock = tx_mode & lock_ok;
endmodule : vrc_vco_model
`default_nettype wire

// ### verilog/vrc_cfg.svh
// Register offsets, field positions, reset values and timing for the VCO range control
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

// Register indices; byte address is four times the index
`define VRC_IDX_BAND        6'h0b
`define VRC_IDX_TUNE        6'h0f
`define VRC_IDX_PUMP        6'h13
`define VRC_IDX_FILT        6'h14
`define VRC_IDX_BIAS        6'h16
`define VRC_IDX_STATUS      6'h18
`define VRC_IDX_MASK        6'h19

// Band and modulation register fields
`define VRC_BAND_SUPMON     7
`define VRC_BAND_SEL_HI     6
`define VRC_BAND_SEL_LO     5
`define VRC_BAND_BANK_HI    4
`define VRC_BAND_BANK_LO    2
// Tune control register fields
`define VRC_TUNE_CHECK      7
`define VRC_TUNE_AUTO       6
`define VRC_TUNE_RELOAD     0
// Pump and first resistor register fields
`define VRC_PUMP_FILT_EN    7
`define VRC_PUMP_CUR_HI     6
`define VRC_PUMP_CUR_LO     5
// Bias and bypass register fields
`define VRC_BIAS_TEST       7
`define VRC_BIAS_OVR_HI     6
`define VRC_BIAS_OVR_LO     4
`define VRC_BIAS_BYPASS     3

// Reset values
`define VRC_RST_BAND        8'hae
`define VRC_RST_TUNE        8'h00
`define VRC_RST_PUMP        8'ha9
`define VRC_RST_FILT        8'he5
`define VRC_RST_BIAS        8'h00
`define VRC_RST_MASK        4'h0

// Output divide ratios per band
`define VRC_DIV_LOWBAND     3'h6
`define VRC_DIV_MIDBAND     3'h4
`define VRC_DIV_HIGHBAND    3'h2

// Timing and window margin
`define VRC_CLK_MHZ         40
`define VRC_TICK_NS         1000
`define VRC_SETTLE_US       10
`define VRC_LOCK_TIMEOUT_US 500
`define VRC_MARGIN_MV       350
`define VRC_ADC_LSB_MV      10

`endif

// ### verilog/vrc_core.sv
// VCO range control: band, bias, bank, monitor, pumps and register file
//
// Operation
// - Band selects output divide 2, 4, 6
// - Band 00 low, 01 mid, 1x high
// - Zero bias override means automatic bias
// - Monitor acts after lock or timeout
// - Monitor runs only if check or autotune
// - Check raises low or high flag
// - Autotune steps bank until voltage in window or bank at 0 or 7
// - Tuned bank kept until programmed bank changes or autotune off
// - Tuned bank readable in status register
// - Check with autotune flags every step
// - Autotune flags lock failure always
// - Check runs on entering transmit
// - Retune on load pulses in transmit
// - One field sets both pump currents
`default_nettype none
`include "vrc_cfg.svh"
module vrc_core #(
  parameter int ADC_W         = 8,
  parameter int SETTLE_US     = `VRC_SETTLE_US,
  parameter int LOCK_TIMEOUT  = `VRC_LOCK_TIMEOUT_US
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // Interrupt
  output logic                  irq,
  // Synthesizer and transmitter status
  input  wire logic             pll_lock,
  input  wire logic             tx_mode,
  input  wire logic             load_pulse,
  input  wire logic             supply_low,
  input  wire logic [ADC_W-1:0] cv_code,
  input  wire logic [ADC_W-1:0] avdd_code,
  // Oscillator controls
  output logic [2:0]            divide_ratio,
  output logic                  bias_auto,
  output logic [2:0]            bias_override,
  output logic [2:0]            cap_bank_setting,
  output logic                  oscillator_bypass,
  // Pump and filter controls
  output logic [1:0]            pump_current_ext,
  output logic [1:0]            pump_current_int,
  output logic                  onchip_filter_enable,
  output logic [4:0]            filter_first_resistor,
  output logic [4:0]            filter_third_resistor,
  output logic [1:0]            filter_capacitor_select,
  output logic                  high_phase_margin,
  // Miscellaneous controls
  output logic                  onchip_filter_test,
  output logic [2:0]            test_output_select,
  output logic                  supply_monitor_enable,
  output logic [1:0]            modulation_select
);
  import vrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Constants
  localparam int TICK_CYC = (`VRC_TICK_NS * `VRC_CLK_MHZ) / 1000;
  localparam logic [9:0] SETTLE_TICKS = 10'(SETTLE_US);
  localparam logic [9:0] LOCK_TICKS   = 10'(LOCK_TIMEOUT);
  localparam logic [7:0] RST_BAND     = `VRC_RST_BAND;  // Band reset, sliceable
  // Register selects
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_BAND = 3'h1;
  localparam logic [2:0] SEL_TUNE = 3'h2;
  localparam logic [2:0] SEL_PUMP = 3'h3;
  localparam logic [2:0] SEL_FILT = 3'h4;
  localparam logic [2:0] SEL_BIAS = 3'h5;
  localparam logic [2:0] SEL_STAT = 3'h6;
  localparam logic [2:0] SEL_MASK = 3'h7;
  // Sticky flag bit positions
  localparam int FL_SUPPLY = 0;
  localparam int FL_LOW    = 1;
  localparam int FL_HIGH   = 2;
  localparam int FL_LOCK   = 3;
  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Address to register select
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    logic [2:0] sel;
    sel = SEL_NONE;
    if (addr[1:0] != 2'h0) begin
      sel = SEL_NONE;
    end else if (addr[7:2] == `VRC_IDX_BAND) begin
      sel = SEL_BAND;
    end else if (addr[7:2] == `VRC_IDX_TUNE) begin
      sel = SEL_TUNE;
    end else if (addr[7:2] == `VRC_IDX_PUMP) begin
      sel = SEL_PUMP;
    end else if (addr[7:2] == `VRC_IDX_FILT) begin
      sel = SEL_FILT;
    end else if (addr[7:2] == `VRC_IDX_BIAS) begin
      sel = SEL_BIAS;
    end else if (addr[7:2] == `VRC_IDX_STATUS) begin
      sel = SEL_STAT;
    end else if (addr[7:2] == `VRC_IDX_MASK) begin
      sel = SEL_MASK;
    end
    return sel;
  endfunction : reg_select
  // Band field to output divide ratio
  function automatic logic [2:0] band_divide(input logic [1:0] band);
    logic [2:0] div;
    if (band[1]) begin
      div = `VRC_DIV_HIGHBAND;
    end else if (band[0]) begin
      div = `VRC_DIV_MIDBAND;
    end else begin
      div = `VRC_DIV_LOWBAND;
    end
    return div;
  endfunction : band_divide
  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  logic tick;                   // One pulse per microsecond

  vrc_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .clock (clock),
    .reset (reset),
    .tick  (tick)
  );
  vrc_window_if win ();         // Comparator results

  vrc_window #(
    .W (ADC_W)
  ) u_window (
    .clock     (clock),
    .reset     (reset),
    .cv_code   (cv_code),
    .avdd_code (avdd_code),
    .win       (win.source)
  );
  ////////////////////////////////////////////////////////////////////////////
  // State
  vrc_core_t st;                // Registered state
  vrc_core_t next_st;           // Next state

  logic [2:0] sel;              // Decoded register
  logic       access;           // Access phase, first cycle
  logic       commit;           // Write takes effect
  logic       chk;              // Range check enabled
  logic       aut;              // Autotune enabled
  logic       trigger;          // Start of a check
  logic [3:0] set_fl;           // Flags raised this cycle
  logic [3:0] clr_fl;           // Flags cleared by software
  logic [2:0] prog_bank;        // Bank as programmed

  assign sel       = reg_select(paddr);
  assign access    = psel & penable & ~st.pready;
  assign commit    = psel & penable & st.pready & pwrite & (sel != SEL_NONE);
  assign chk       = st.cfg_tune[`VRC_TUNE_CHECK];
  assign aut       = st.cfg_tune[`VRC_TUNE_AUTO];
  assign prog_bank = st.cfg_band[`VRC_BAND_BANK_HI:`VRC_BAND_BANK_LO];

  // Start on transmit entry, or on load while transmitting
  assign trigger = (tx_mode & ~st.tx_prev)
                 | (tx_mode & load_pulse & st.cfg_tune[`VRC_TUNE_RELOAD]);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    set_fl  = 4'h0;
    clr_fl  = 4'h0;
    next_st.tx_prev = tx_mode;
    // Bus answer: one wait state, data and error ready with pready
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    if (access) begin
      next_st.pslverr = (sel == SEL_NONE);
      if (sel == SEL_BAND) begin
        next_st.prdata = {24'h00_0000, st.cfg_band};
      end else if (sel == SEL_TUNE) begin
        next_st.prdata = {24'h00_0000, st.cfg_tune};
      end else if (sel == SEL_PUMP) begin
        next_st.prdata = {24'h00_0000, st.cfg_pump};
      end else if (sel == SEL_FILT) begin
        next_st.prdata = {24'h00_0000, st.cfg_filt};
      end else if (sel == SEL_BIAS) begin
        next_st.prdata = {24'h00_0000, st.cfg_bias};
      end else if (sel == SEL_STAT) begin
        next_st.prdata = {24'h00_0000, st.tuned, 1'b0, st.sticky};
      end else if (sel == SEL_MASK) begin
        next_st.prdata = {28'h000_0000, st.mask};
      end
    end
    // Register writes
    if (commit) begin
      if (sel == SEL_BAND) begin
        next_st.cfg_band = pwdata[7:0];
      end else if (sel == SEL_TUNE) begin
        next_st.cfg_tune = pwdata[7:0];
      end else if (sel == SEL_PUMP) begin
        next_st.cfg_pump = pwdata[7:0];
      end else if (sel == SEL_FILT) begin
        next_st.cfg_filt = pwdata[7:0];
      end else if (sel == SEL_BIAS) begin
        next_st.cfg_bias = pwdata[7:0];
      end else if (sel == SEL_STAT) begin
        clr_fl = pwdata[3:0];
      end else if (sel == SEL_MASK) begin
        next_st.mask = pwdata[3:0];
      end
    end
    // Supply monitor flag while enabled
    if (supply_low && st.cfg_band[`VRC_BAND_SUPMON]) begin
      set_fl[FL_SUPPLY] = 1'b1;
    end
    // Monitor sequence
    case (st.seq)
      ST_IDLE: begin
        if (trigger && (chk || aut)) begin
          next_st.seq = ST_LOCK;
          next_st.tmr = 10'h000;
        end
      end
      ST_LOCK: begin
        if (pll_lock) begin
          next_st.seq = ST_EVAL;
        end else if (tick) begin
          if (st.tmr == LOCK_TICKS - 10'h001) begin
            next_st.seq = ST_EVAL;
            if (aut) begin
              set_fl[FL_LOCK] = 1'b1;
            end
          end else begin
            next_st.tmr = st.tmr + 10'h001;
          end
        end
      end
      ST_SETTL: begin
        // Let the loop settle after a bank step
        if (tick) begin
          if (st.tmr == SETTLE_TICKS - 10'h001) begin
            next_st.seq = ST_EVAL;
          end else begin
            next_st.tmr = st.tmr + 10'h001;
          end
        end
      end
      ST_EVAL: begin
        next_st.seq = ST_IDLE;
        if (win.below_low) begin
          if (chk) begin
            set_fl[FL_LOW] = 1'b1;
          end
          if (aut && st.tuned != 3'h7) begin
            next_st.tuned = st.tuned + 3'h1;
            next_st.seq   = ST_SETTL;
            next_st.tmr   = 10'h000;
          end
        end else if (win.above_high) begin
          if (chk) begin
            set_fl[FL_HIGH] = 1'b1;
          end
          if (aut && st.tuned != 3'h0) begin
            next_st.tuned = st.tuned - 3'h1;
            next_st.seq   = ST_SETTL;
            next_st.tmr   = 10'h000;
          end
        end
      end
      default: begin
        next_st.seq = ST_IDLE;
      end
    endcase
    // Disabling both modes abandons a running check
    if (!chk && !aut) begin
      next_st.seq = ST_IDLE;
    end
    // Tuned bank kept until programmed bank changes or autotune is off
    if (!aut) begin
      next_st.tuned = prog_bank;
    end
    if (commit && sel == SEL_BAND &&
        pwdata[`VRC_BAND_BANK_HI:`VRC_BAND_BANK_LO] != prog_bank) begin
      next_st.tuned = pwdata[`VRC_BAND_BANK_HI:`VRC_BAND_BANK_LO];
    end

    // Sticky flags, a set wins over a clear
    next_st.sticky = (st.sticky & ~clr_fl) | set_fl;

    // Interrupt level
    next_st.irq = |(next_st.sticky & next_st.mask);

    // Derived oscillator controls
    next_st.divide    = band_divide(next_st.cfg_band[`VRC_BAND_SEL_HI:`VRC_BAND_SEL_LO]);
    next_st.bias_auto =
      (next_st.cfg_bias[`VRC_BIAS_OVR_HI:`VRC_BIAS_OVR_LO] == 3'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st          <= '0;
      st.cfg_band <= `VRC_RST_BAND;
      st.cfg_tune <= `VRC_RST_TUNE;
      st.cfg_pump <= `VRC_RST_PUMP;
      st.cfg_filt <= `VRC_RST_FILT;
      st.cfg_bias <= `VRC_RST_BIAS;
      st.mask     <= `VRC_RST_MASK;
      st.tuned    <= RST_BAND[`VRC_BAND_BANK_HI:`VRC_BAND_BANK_LO];
      st.seq      <= ST_IDLE;
      st.divide   <= `VRC_DIV_MIDBAND;
      st.bias_auto <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from state flip-flops
  // Bus and interrupt
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign prdata  = st.prdata;
  assign irq     = st.irq;

  // Oscillator
  assign divide_ratio      = st.divide;
  assign bias_auto         = st.bias_auto;
  assign bias_override     = st.cfg_bias[`VRC_BIAS_OVR_HI:`VRC_BIAS_OVR_LO];
  assign cap_bank_setting  = st.tuned;
  assign oscillator_bypass = st.cfg_bias[`VRC_BIAS_BYPASS];

  // Both pumps share one current field
  assign pump_current_ext = st.cfg_pump[`VRC_PUMP_CUR_HI:`VRC_PUMP_CUR_LO];
  assign pump_current_int = st.cfg_pump[`VRC_PUMP_CUR_HI:`VRC_PUMP_CUR_LO];

  // Filter
  assign onchip_filter_enable    = st.cfg_pump[`VRC_PUMP_FILT_EN];
  assign filter_first_resistor   = st.cfg_pump[4:0];
  assign filter_third_resistor   = st.cfg_filt[4:0];
  assign filter_capacitor_select = st.cfg_filt[6:5];
  assign high_phase_margin       = st.cfg_filt[7];

  // Miscellaneous
  assign onchip_filter_test    = st.cfg_bias[`VRC_BIAS_TEST];
  assign test_output_select    = st.cfg_bias[2:0];
  assign supply_monitor_enable = st.cfg_band[`VRC_BAND_SUPMON];
  assign modulation_select     = st.cfg_band[1:0];

endmodule : vrc_core
`default_nettype wire

// ### verilog/vrc_pkg.sv
// Types shared by the VCO range control modules
`default_nettype none
package vrc_pkg;

  // Monitor sequence states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LOCK  = 4'h2,
    ST_SETTL = 4'h4,
    ST_EVAL  = 4'h8
  } vrc_seq_t;

  // Whole state of the core
  typedef struct packed {
    logic [7:0]  cfg_band;      // Band, bank, modulation
    logic [7:0]  cfg_tune;      // Check, autotune, retune
    logic [7:0]  cfg_pump;      // Pump current, first resistor
    logic [7:0]  cfg_filt;      // Filter capacitor, third resistor
    logic [7:0]  cfg_bias;      // Bias override, bypass, test
    logic [3:0]  mask;          // Interrupt mask
    logic [3:0]  sticky;        // Lock fail, high, low, supply
    logic [2:0]  tuned;         // Bank in use
    vrc_seq_t    seq;           // Monitor state
    logic [9:0]  tmr;           // Tick counter
    logic        tx_prev;       // Last transmit level
    logic        pready;        // Bus answer
    logic        pslverr;       // Bus error
    logic [31:0] prdata;        // Bus read data
    logic        irq;           // Interrupt level
    logic [2:0]  divide;        // Output divide ratio
    logic        bias_auto;     // Automatic bias in use
  } vrc_core_t;

  // Window comparator state
  typedef struct packed {
    logic below;                // Under low limit
    logic above;                // Over high limit
  } vrc_win_t;

  // Tick divider state
  typedef struct packed {
    logic [7:0] cnt;            // Cycle counter
    logic       tick;           // Enable pulse
  } vrc_tick_t;

endpackage : vrc_pkg
`default_nettype wire

// ### verilog/vrc_tick.sv
// Divider giving a one-cycle enable pulse at the tick rate
`default_nettype none
`include "vrc_cfg.svh"
module vrc_tick #(
  parameter int DIV = 40
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Enable pulse
  output logic      tick
);
  import vrc_pkg::*;

  vrc_tick_t st;                // Registered state
  vrc_tick_t next_st;           // Next state

  // Count cycles and pulse at wrap
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 8'(DIV - 1)) begin
      next_st.cnt  = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : vrc_tick
`default_nettype wire

// ### verilog/vrc_window.sv
// Varactor voltage window comparator
`default_nettype none
`include "vrc_cfg.svh"
module vrc_window #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Converted voltages
  input  wire logic [W-1:0] cv_code,
  input  wire logic [W-1:0] avdd_code,
  // Results
  vrc_window_if.source      win
);
  import vrc_pkg::*;

  localparam logic [W-1:0] MARGIN = W'(`VRC_MARGIN_MV / `VRC_ADC_LSB_MV);

  vrc_win_t st;                 // Registered state
  vrc_win_t next_st;            // Next state

  // Compare against both limits
  always_comb begin
    next_st.below = cv_code < MARGIN;
    next_st.above = (avdd_code > MARGIN) ? (cv_code > (avdd_code - MARGIN)) : 1'b1;
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign win.below_low  = st.below;
  assign win.above_high = st.above;
endmodule : vrc_window
`default_nettype wire

// ### verilog/vrc_window_if.sv
// Window comparison results passed from comparator to core
`default_nettype none
interface vrc_window_if;
  logic below_low;              // Voltage under low limit
  logic above_high;             // Voltage over high limit
  modport source (output below_low, output above_high);
  modport sink   (input  below_low, input  above_high);
endinterface : vrc_window_if
`default_nettype wire
